// ---- flash_map.svh ----
// Link opcodes, status bit positions, timing figures and host register map.
// Included by the package; assumes nothing else.
`ifndef FLASH_MAP_SVH
`define FLASH_MAP_SVH

// Command codes
`define OP_WREN 8'h06
`define OP_WRDI 8'h04
`define OP_PP   8'h02
`define OP_DPP  8'hA2
`define OP_XDPP 8'hD2
`define OP_QPP  8'h32
`define OP_XQPP 8'h38
`define OP_RDFS 8'h70
`define OP_CLFS 8'h50

// Flag status bit positions
`define FS_READY 7
`define FS_PFAIL 4
`define FS_PROT  1

// Timing
`define CLK_NS        10
`define PP_TIME_NS    5000
`define SCLK_HALF_CYC 8

// Address length and clock count bases per lane width
`define ADDR_BITS 24
`define CX_BASE_1 7
`define CX_BASE_2 3
`define CX_BASE_4 1

// Host register offsets and command fields
`define HREG_CMD   8'h00
`define HREG_ADDR  8'h04
`define HREG_DATA  8'h08
`define HREG_CFG   8'h0C
`define HREG_STAT  8'h10
`define HCMD_NB_LSB 8
`define HCMD_POLL   24

`endif

// ---- flash_pkg.sv ----
// Shared types and lane helpers for both link ends.
// Assumes flash_map.svh is on the include path.
`include "flash_map.svh"
package flash_pkg;
	typedef enum logic [1:0] {PROTO_EXT, PROTO_DUAL, PROTO_QUAD} proto_t;
	typedef enum logic [2:0] {D_CMD, D_ADDR, D_DATA, D_TAIL, D_READ, D_SKIP} dev_st_t;
	typedef enum logic [2:0] {H_IDLE, H_CMD, H_ADDR, H_WAIT, H_DATA, H_READ, H_END} host_st_t;

	// Lane count of a protocol
	function automatic logic [2:0] lanes_of(input proto_t p);
		lanes_of = (p == PROTO_QUAD) ? 3'd4 : (p == PROTO_DUAL) ? 3'd2 : 3'd1;
	endfunction : lanes_of

	function automatic logic is_prog(input logic [7:0] op);
		is_prog = op inside {`OP_PP, `OP_DPP, `OP_XDPP, `OP_QPP, `OP_XQPP};
	endfunction : is_prog

	// Two-lane variants barred in quad protocol, four-lane ones in dual
	function automatic logic op_ok(input logic [7:0] op, input proto_t p);
		op_ok = !((op inside {`OP_DPP, `OP_XDPP}) && p == PROTO_QUAD) &&
			!((op inside {`OP_QPP, `OP_XQPP}) && p == PROTO_DUAL);
	endfunction : op_ok

	// Address lanes: extended variants widen, otherwise protocol width
	function automatic logic [2:0] op_alanes(input logic [7:0] op, input proto_t p);
		op_alanes = (op == `OP_XQPP) ? 3'd4 : (op == `OP_XDPP) ? 3'd2 : lanes_of(p);
	endfunction : op_alanes

	function automatic logic [2:0] op_dlanes(input logic [7:0] op, input proto_t p);
		op_dlanes = (op inside {`OP_QPP, `OP_XQPP}) ? 3'd4 :
			(op inside {`OP_DPP, `OP_XDPP}) ? 3'd2 : lanes_of(p);
	endfunction : op_dlanes

	// Clock index of the last address bit; dtr halves the address clocks
	function automatic logic [7:0] cx_count(input logic [2:0] n, input logic dtr, input logic [7:0] abits);
		logic [7:0] base;
		logic [3:0] dv;
		base = (n == 3'd4) ? 8'(`CX_BASE_4) : (n == 3'd2) ? 8'(`CX_BASE_2) : 8'(`CX_BASE_1);
		dv = dtr ? {n, 1'b0} : {1'b0, n};
		cx_count = base + abits / {4'h0, dv};
	endfunction : cx_count

	// Shift lanes in at the bottom, first bit lands highest
	function automatic logic [31:0] shift_in(input logic [31:0] sh, input logic [3:0] d, input logic [2:0] n);
		shift_in = (n == 3'd4) ? {sh[27:0], d} : (n == 3'd2) ? {sh[29:0], d[1:0]} : {sh[30:0], d[0]};
	endfunction : shift_in

	function automatic logic [31:0] shift_out(input logic [31:0] sh, input logic [2:0] n);
		shift_out = (n == 3'd4) ? {sh[27:0], 4'h0} : (n == 3'd2) ? {sh[29:0], 2'h0} : {sh[30:0], 1'h0};
	endfunction : shift_out

	// Top bits onto lanes; single-lane reads use lane one
	function automatic logic [3:0] tx_lanes(input logic [3:0] t, input logic [2:0] n, input logic rd);
		tx_lanes = (n == 3'd4) ? t : (n == 3'd2) ? {2'h0, t[3:2]} : rd ? {2'h0, t[3], 1'h0} : {3'h0, t[3]};
	endfunction : tx_lanes

	function automatic logic [3:0] lane_mask(input logic [2:0] n, input logic rd);
		lane_mask = (n == 3'd4) ? 4'hF : (n == 3'd2) ? 4'h3 : rd ? 4'h2 : 4'h1;
	endfunction : lane_mask

	// Gather read data to lane zero when one lane is used
	function automatic logic [3:0] rx_lanes(input logic [3:0] d, input logic [2:0] n);
		rx_lanes = (n == 3'd1) ? {3'h0, d[1]} : d;
	endfunction : rx_lanes
endpackage : flash_pkg

// ---- flash_link_if.sv ----
// Serial flash link between host and device ends.
// Undriven lanes read high, as if pulled up.
`timescale 1ns/1ns
interface flash_link_if;
	logic       sclk;     // Link clock from host
	logic       cs_n;     // Chip select, active low
	logic [3:0] h_dq_o;   // Host lane values
	logic [3:0] h_dq_e;   // Host lane enables
	logic [3:0] d_dq_o;   // Device lane values
	logic [3:0] d_dq_e;   // Device lane enables
	logic [3:0] dq;       // Resolved lanes, serial_lane_zero is bit 0

	// Resolve each lane from the enables
	assign dq = (h_dq_o & h_dq_e) | (d_dq_o & d_dq_e) | ~(h_dq_e | d_dq_e);

	modport host (output sclk, output cs_n, output h_dq_o, output h_dq_e, input dq);
	modport dev (input sclk, input cs_n, output d_dq_o, output d_dq_e, input dq);
endinterface : flash_link_if

// ---- flash_host.sv ----
// Host end: drives the link clock, chip select and lanes on register orders.
// Assumes a device end on the same link and software on the register port.
`timescale 1ns/1ns
module flash_host (
	input  wire logic                clock,    // 100 MHz clock
	input  wire logic                nrst,     // Sync reset, active low
	input  wire logic [7:0]          addr,     // Register byte address
	input  wire logic [31:0]         wdata,    // Write data
	input  wire logic                wr,       // Write strobe
	input  wire logic                rd,       // Read strobe
	output      logic [31:0]         rdata,    // Read data, cycle after rd
	flash_link_if.host               link      // Link pins
);
	import flash_pkg::*;

	typedef struct packed {
		logic [3:0]  s1;       // Lane sync stage one
		logic [3:0]  s2;       // Lane sync stage two
		host_st_t    st;       // Frame state
		logic [7:0]  div;      // Half period counter
		logic        sclk;     // Link clock level
		logic        cs_n;     // Chip select level
		logic [31:0] sh;       // Outgoing bits, msb first
		logic [5:0]  left;     // Bits left in phase
		logic [2:0]  n;        // Lanes of phase
		logic [7:0]  rx;       // Incoming byte
		logic [7:0]  op;       // Command code
		logic [8:0]  nb;       // Data bytes left
		logic        poll;     // Repeat status reads until ready
		logic [23:0] fa;       // Flash address
		proto_t      proto;    // Link protocol
		logic [7:0]  dbyte;    // Next data byte
		logic        dfull;    // Data byte waiting
		logic [7:0]  fsr;      // Last status byte read
		logic [7:0]  clks;     // Rising edges in frame
		logic        cx_ok;    // Address ended at the expected clock
		logic [3:0]  dq_o;     // Lane values
		logic [3:0]  dq_e;     // Lane enables
		logic [31:0] rdata;    // Read data
	} host_t;

	host_t r, x;
	logic  tick;               // Half period elapsed

	assign tick = (r.div == 8'(`SCLK_HALF_CYC - 1));

	// Next state of the whole host
	always_comb begin
		x = r;
		x.s1 = link.dq;
		x.s2 = r.s1;
		x.div = tick ? 8'h00 : r.div + 8'h01;
		// Register reads answer in the next cycle
		x.rdata = 32'h0;
		if (rd) begin
			case (addr)
				`HREG_CMD:  x.rdata = {7'h0, r.poll, 7'h0, r.nb, r.op};
				`HREG_ADDR: x.rdata = {8'h0, r.fa};
				`HREG_CFG:  x.rdata = {30'h0, r.proto};
				`HREG_STAT: x.rdata = {16'h0, r.fsr, 5'h0, r.cx_ok, r.st == H_WAIT && !r.dfull, r.st != H_IDLE};
				default:    x.rdata = 32'h0;
			endcase
		end
		// Register writes; a command while busy is dropped
		if (wr) begin
			case (addr)
				`HREG_ADDR: x.fa = wdata[23:0];
				`HREG_DATA: begin
					x.dbyte = wdata[7:0];
					x.dfull = 1'b1;
				end
				`HREG_CFG: x.proto = proto_t'(wdata[1:0]);
				`HREG_CMD: if (r.st == H_IDLE) begin
					x.op = wdata[7:0];
					x.nb = wdata[`HCMD_NB_LSB +: 9];
					x.poll = wdata[`HCMD_POLL];
					x.cs_n = 1'b0;
					x.sh = {wdata[7:0], 24'h0};
					x.n = lanes_of(r.proto);
					x.left = 6'd8;
					x.st = H_CMD;
					x.div = 8'h00;
					x.clks = 8'h00;
				end
				default: ;
			endcase
		end
		case (r.st)
			H_IDLE: ;
			// Stall with clock low until software supplies a byte
			H_WAIT: if (r.dfull) begin
				x.sh = {r.dbyte, 24'h0};
				x.left = 6'd8;
				x.dfull = 1'b0;
				x.st = H_DATA;
				x.div = 8'h00;
			end
			// Hold clock low a half period, then end the frame
			H_END: if (tick) begin
				x.cs_n = 1'b1;
				x.st = H_IDLE;
			end
			default: if (tick) begin
				if (!r.sclk) begin
					// Rising edge: device samples, host captures read lanes
					x.sclk = 1'b1;
					x.clks = r.clks + 8'h01;
					if (r.st == H_READ)
						x.rx = 8'(shift_in({24'h0, r.rx}, rx_lanes(r.s2, r.n), r.n));
				end else begin
					x.sclk = 1'b0;
					x.sh = shift_out(r.sh, r.n);
					x.left = r.left - {3'h0, r.n};
					if (r.left == {3'h0, r.n}) begin
						case (r.st)
							// Program needs address, status read needs data
							H_CMD: if (is_prog(r.op)) begin
								x.st = H_ADDR;
								x.sh = {r.fa, 8'h0};
								x.left = 6'(`ADDR_BITS);
								x.n = op_alanes(r.op, r.proto);
							end else if (r.op == `OP_RDFS) begin
								x.st = H_READ;
								x.left = 6'd8;
								x.rx = 8'h00;
							end else
								// Bytes after a short code spoil its framing on purpose
								x.st = (r.nb == 9'h0) ? H_END : H_WAIT;
							H_ADDR: begin
								x.cx_ok = (r.clks == cx_count(r.n, 1'b0, 8'(`ADDR_BITS)) + 8'h01);
								x.n = op_dlanes(r.op, r.proto);
								x.st = (r.nb == 9'h0) ? H_END : H_WAIT;
							end
							H_DATA: begin
								x.nb = r.nb - 9'h1;
								x.st = (r.nb == 9'h1) ? H_END : H_WAIT;
							end
							// Keep polling while the controller is busy
							H_READ: begin
								x.fsr = r.rx;
								x.left = 6'd8;
								if (!(r.poll && !r.rx[`FS_READY]))
									x.st = H_END;
							end
							default: x.st = H_END;
						endcase
					end
				end
			end
		endcase
		// Drive write lanes only outside reads and idle
		x.dq_o = tx_lanes(x.sh[31:28], x.n, 1'b0);
		x.dq_e = (x.st inside {H_CMD, H_ADDR, H_WAIT, H_DATA}) ? lane_mask(x.n, 1'b0) : 4'h0;
	end

	// Register the whole host state
	always_ff @(posedge clock) begin
		if (!nrst) begin
			r <= '0;
			r.st <= H_IDLE;
			r.cs_n <= 1'b1;
			r.proto <= PROTO_EXT;
		end else
			r <= x;
	end

	assign link.sclk = r.sclk;
	assign link.cs_n = r.cs_n;
	assign link.h_dq_o = r.dq_o;
	assign link.h_dq_e = r.dq_e;
	assign rdata = r.rdata;
endmodule : flash_host

// ---- flash_dev.sv ----
// Device end: serial flash command decoder, page program and enable latch.
// Assumes the host makes sclk and cs_n; all link pins are synchronised here.
// Operation
// - address end clock follows lane count formula
// - program needs write enable latch set
// - host raises select after last data bit
// - code, address, then at least one byte
// - select rise starts timed program
// - bytes past page end wrap to start
// - excess bytes: only last page kept
// - short program touches only addressed bytes
// - ready bit zero while busy, one after
// - program end clears write enable latch
// - host waits for status bit seven
// - timeout clears latch, sets fail flag
// - misplaced select rise: nothing happens
// - protected sector: refuse, flag bits one, four
// - host polls status also after timeout
// - two-lane variants barred in quad protocol
// - four-lane variants barred in dual protocol
// - code 06h sets write enable latch
// - host enables writes before every program
// - misframed enable code is ignored
// - code 04h clears latch when framed
// - protection error: only clear-flags drops latch
`timescale 1ns/1ns
module flash_dev #(
	parameter int PAGE_BYTES   = 256,  // Program page size
	parameter int MEM_BYTES    = 4096, // Modelled array size
	parameter int SECTOR_BYTES = 1024  // Protection granule
) (
	input  wire logic                  clock,         // 100 MHz clock
	input  wire logic                  nrst,          // Sync reset, active low
	flash_link_if.dev                  link,          // Link pins
	input  wire flash_pkg::proto_t     proto,         // Link protocol
	input  wire logic [MEM_BYTES/SECTOR_BYTES-1:0] sector_lock, // Locked sectors
	input  wire logic                  timeout_force, // Make next program time out
	input  wire logic [$clog2(MEM_BYTES)-1:0] mem_addr, // Array peek address
	output      logic [7:0]            mem_data,      // Array peek data, one cycle
	output      logic                  wel,           // Write enable latch
	output      logic [7:0]            fsr,           // Flag status byte
	output      logic                  busy           // Program running
);
	import flash_pkg::*;

	localparam int PW = $clog2(PAGE_BYTES);   // Page offset width
	localparam int MW = $clog2(MEM_BYTES);    // Array address width
	localparam int SW = $clog2(SECTOR_BYTES); // Sector offset width
	// Longest time rounds down to whole cycles
	localparam int PP_CYCLES = `PP_TIME_NS / `CLK_NS;
	localparam logic [15:0] PP_LAST = 16'(PP_CYCLES - 1); // page_program_time end

	typedef struct packed {
		logic [5:0]  s1;       // Pin sync stage one
		logic [5:0]  s2;       // Pin sync stage two
		logic        sclk_q;   // Last synced clock
		logic        cs_q;     // Last synced select
		dev_st_t     st;       // Frame state
		logic [5:0]  cnt;      // Bits in current phase
		logic [31:0] sh;       // Incoming bits
		logic [7:0]  op;       // Command code
		logic [MW-1:0] base;   // Program start address
		logic [PW-1:0] ptr;    // Page buffer write offset
		logic        got;      // At least one data byte
		logic [PAGE_BYTES-1:0] vld; // Page bytes received
		logic        wel;      // Write enable latch
		logic        busy;     // Program running
		logic        fail;     // Program failure flag
		logic        prot;     // Protection error flag
		logic        tmo;      // Pending program will time out
		logic [7:0]  osh;      // Outgoing status bits
		logic [3:0]  dq_o;     // Lane values
		logic [3:0]  dq_e;     // Lane enables
		logic [PW:0] idx;      // Commit walk position
		logic [15:0] tmr;      // Program time counter
		logic [7:0]  mdat;     // Peek data
	} dev_t;

	dev_t        r, x;
	logic [7:0]  mem [MEM_BYTES];   // Flash array
	logic [7:0]  pbuf [PAGE_BYTES]; // Page buffer
	logic [2:0]  n;                 // Lanes of current phase
	logic [31:0] nsh;               // Shift register with new lanes
	logic [5:0]  ncnt;              // Bit count with new lanes
	logic        rise, fall, csup, csh; // Synced link events
	logic [7:0]  fs;                // Live flag status
	logic        pb_we;             // Page buffer write
	logic        m_we;              // Array write
	logic [MW-1:0] m_wa;            // Array write address
	logic [7:0]  m_wd;              // Array write data

	// Only stage two of the synchroniser is looked at
	assign csh  = r.s2[5];
	assign rise = r.s2[4] & ~r.sclk_q;
	assign fall = ~r.s2[4] & r.sclk_q;
	assign csup = csh & ~r.cs_q;

	// Live status: ready is the inverse of busy
	always_comb begin
		fs = 8'h00;
		fs[`FS_READY] = ~r.busy;
		fs[`FS_PFAIL] = r.fail | r.prot;
		fs[`FS_PROT]  = r.prot;
	end

	// Lanes per phase, then new shift value
	always_comb begin
		case (r.st)
			D_ADDR:  n = op_alanes(r.op, proto);
			D_DATA:  n = op_dlanes(r.op, proto);
			default: n = lanes_of(proto);
		endcase
		nsh = shift_in(r.sh, r.s2[3:0], n);
		ncnt = r.cnt + {3'h0, n};
	end

	// Next state of the whole device
	always_comb begin
		x = r;
		x.s1 = {link.cs_n, link.sclk, link.dq};
		x.s2 = r.s1;
		x.sclk_q = r.s2[4];
		x.cs_q = csh;
		x.mdat = mem[mem_addr];
		pb_we = 1'b0;
		m_we = 1'b0;
		m_wa = {r.base[MW-1:PW], r.idx[PW-1:0]};
		m_wd = pbuf[r.idx[PW-1:0]];
		// Self-timed program: walk the page, then wait out the time
		if (r.busy) begin
			x.tmr = r.tmr + 16'h1;
			if (r.idx < (PW+1)'(PAGE_BYTES)) begin
				m_we = r.vld[r.idx[PW-1:0]];
				x.idx = r.idx + (PW+1)'(1);
			end
			if (r.tmr == PP_LAST) begin
				x.busy = 1'b0;
				x.wel = 1'b0;
				x.fail = r.fail | r.tmo;
			end
		end
		if (csh) begin
			// Select high: act only on a frame that ended cleanly
			if (csup) begin
				case (r.st)
					D_TAIL: case (r.op)
						`OP_WREN: x.wel = 1'b1;
						`OP_WRDI: if (!r.prot) x.wel = 1'b0;
						`OP_CLFS: begin
							if (r.prot) x.wel = 1'b0;
							x.fail = 1'b0;
							x.prot = 1'b0;
						end
						default: ;
					endcase
					// Whole bytes only; half a byte drops the frame
					D_DATA: if (r.cnt == 6'h0 && r.got && r.wel) begin
						if (sector_lock[r.base[MW-1:SW]])
							x.prot = 1'b1;
						else begin
							x.busy = 1'b1;
							x.tmr = 16'h0;
							x.idx = '0;
							x.tmo = timeout_force;
						end
					end
					default: ;
				endcase
			end
			x.st = D_CMD;
			x.cnt = 6'h0;
			x.dq_e = 4'h0;
		end else if (rise) begin
			x.sh = nsh;
			x.cnt = ncnt;
			case (r.st)
				// Command byte: decode and choose the next phase
				D_CMD: if (ncnt == 6'd8) begin
					x.op = nsh[7:0];
					x.cnt = 6'h0;
					if (r.busy)
						x.st = (nsh[7:0] == `OP_RDFS) ? D_READ : D_SKIP;
					else if (nsh[7:0] inside {`OP_WREN, `OP_WRDI, `OP_CLFS})
						x.st = D_TAIL;
					else if (nsh[7:0] == `OP_RDFS)
						x.st = D_READ;
					else if (is_prog(nsh[7:0]) && op_ok(nsh[7:0], proto))
						x.st = D_ADDR;
					else
						x.st = D_SKIP;
				end
				// Address sampled on rising edges; last bit opens the page
				D_ADDR: if (ncnt == 6'(`ADDR_BITS)) begin
					x.base = nsh[MW-1:0];
					x.ptr = nsh[PW-1:0];
					x.vld = '0;
					x.got = 1'b0;
					x.cnt = 6'h0;
					x.st = D_DATA;
				end
				// Each byte lands at ptr, which wraps inside the page
				D_DATA: if (ncnt == 6'd8) begin
					pb_we = 1'b1;
					x.vld[r.ptr] = 1'b1;
					x.ptr = r.ptr + PW'(1);
					x.got = 1'b1;
					x.cnt = 6'h0;
				end
				// Any clock after a short command spoils it
				D_TAIL: x.st = D_SKIP;
				D_READ: x.cnt = r.cnt;
				default: x.st = D_SKIP;
			endcase
		end else if (fall && r.st == D_READ) begin
			// Status streams out, fresh byte each boundary
			x.osh = (r.cnt == 6'h0) ? fs : r.osh;
			x.dq_o = tx_lanes(x.osh[7:4], n, 1'b1);
			x.dq_e = lane_mask(n, 1'b1);
			x.osh = 8'(shift_out({24'h0, x.osh}, n));
			x.cnt = (ncnt == 6'd8) ? 6'h0 : ncnt;
		end
	end

	// Array and page buffer; no reset, contents are data
	always_ff @(posedge clock) begin
		if (pb_we)
			pbuf[r.ptr] <= nsh[7:0];
		if (m_we)
			mem[m_wa] <= m_wd;
	end

	// Register the whole device state
	always_ff @(posedge clock) begin
		if (!nrst) begin
			r <= '0;
			// Idle pin levels: select high, clock low, lanes pulled up
			r.s1 <= 6'h2F;
			r.s2 <= 6'h2F;
			r.cs_q <= 1'b1;
			r.st <= D_CMD;
		end else
			r <= x;
	end

	assign link.d_dq_o = r.dq_o;
	assign link.d_dq_e = r.dq_e;
	assign mem_data = r.mdat;
	assign wel = r.wel;
	assign busy = r.busy;
	assign fsr = fs;
endmodule : flash_dev

// ---- flash_link_checker.sv ----
// Link checker: clock shape, framing and lane ownership.
// Assumes both ends share one link; sees link pins only.
`timescale 1ns/1ns
module flash_link_checker (
	input wire logic       clock,  // System clock
	input wire logic       nrst,   // Sync reset, active low
	input wire logic       sclk,   // Link clock
	input wire logic       cs_n,   // Select, active low
	input wire logic [3:0] h_dq_o, // Host lane values
	input wire logic [3:0] h_dq_e, // Host lane enables
	input wire logic [3:0] d_dq_o, // Device lane values
	input wire logic [3:0] d_dq_e, // Device lane enables
	input wire logic [3:0] dq      // Resolved lanes
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	// Select falls, eight low clocks, then first rise
	sequence lead_s;
		!sclk [*8] ##1 sclk;
	endsequence
	// Full high half period
	sequence high_s;
		sclk [*8] ##1 !sclk;
	endsequence
	a_one_owner: assert property ((h_dq_e & d_dq_e) == 4'h0)
		else $error("both ends drive a lane");
	a_clk_idle: assert property (cs_n |-> !sclk)
		else $error("link clock high while deselected");
	a_cs_setup: assert property ($fell(cs_n) |-> lead_s)
		else $error("first clock rise misplaced");
	a_high_half: assert property ($rose(sclk) |-> high_s)
		else $error("link clock high phase wrong");
	a_low_half: assert property ($fell(sclk) |-> !sclk [*8])
		else $error("link clock low phase short");
	// Host lanes settle before the rise, the device samples there
	a_host_stable: assert property ($rose(sclk) |=> $stable(h_dq_o & h_dq_e) [*7])
		else $error("host lanes move while clock high");
	a_dev_stable: assert property ($rose(sclk) |=> $stable(d_dq_o & d_dq_e) [*7])
		else $error("device lanes move while clock high");
	a_cs_hold: assert property ($rose(cs_n) |-> !$past(sclk, 8) && !$past(sclk, 2))
		else $error("select rose too soon after last bit");
	a_lanes_free: assert property (cs_n [*5] |-> (h_dq_e | d_dq_e) == 4'h0 && dq == 4'hF)
		else $error("lane driven outside a frame");
endmodule : flash_link_checker

// ---- test_serial_flash_program_write_enable.sv ----
// Bench: host and device ends joined, driven by register calls.
// Assumes design files and the link checker are compiled first.
`timescale 1ns/1ns
module test_serial_flash_program_write_enable;
	import flash_pkg::*;
	logic        clock = 0, nrst = 0, wr = 0, rd = 0, timeout_force = 0, wel, busy, ok;
	logic [7:0]  addr = 8'h00, mem_data, fsr, v;
	logic [31:0] wdata = 32'h0, rdata, s;
	logic [11:0] mem_addr = 12'h000, a;
	logic [3:0]  sector_lock = 4'h0;
	proto_t      proto = PROTO_EXT;
	int          err_count = 0, checked = 0, cyc = 0;
	logic [7:0]  ops [5] = '{`OP_PP, `OP_DPP, `OP_XDPP, `OP_QPP, `OP_XQPP};
	flash_link_if link ();
	flash_host flash_host_i (.clock(clock), .nrst(nrst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .link(link));
	flash_dev flash_dev_i (.clock(clock), .nrst(nrst), .link(link), .proto(proto),
		.sector_lock(sector_lock), .timeout_force(timeout_force), .mem_addr(mem_addr),
		.mem_data(mem_data), .wel(wel), .fsr(fsr), .busy(busy));
	flash_link_checker flash_link_checker_i (.clock(clock), .nrst(nrst), .sclk(link.sclk),
		.cs_n(link.cs_n), .h_dq_o(link.h_dq_o), .h_dq_e(link.h_dq_e), .d_dq_o(link.d_dq_o),
		.d_dq_e(link.d_dq_e), .dq(link.dq));
	always #5 clock = ~clock;
	// Hang guard, well above the longest expected run
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 90000) begin
			err_count++;
			conclude();
		end
	end
	task conclude;
		$display("checks %0d errors %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : conclude
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask : chk
	// One-cycle write strobe
	task wreg(input logic [7:0] ad, input logic [31:0] d);
		@(posedge clock) addr <= ad;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock) wr <= 1'b0;
	endtask : wreg
	// Read data stands only in the cycle after the strobe
	task rreg(input logic [7:0] ad);
		@(posedge clock) addr <= ad;
		rd <= 1'b1;
		@(posedge clock) rd <= 1'b0;
		#1 s = rdata;
	endtask : rreg
	// Poll status until masked bits match, bounded
	task await(input logic [31:0] m, input logic [31:0] w);
		int n;
		n = 0;
		rreg(`HREG_STAT);
		while ((s & m) !== w && n < 30000) begin
			rreg(`HREG_STAT);
			n++;
		end
		if (n == 30000) begin
			err_count++;
			$display("MISMATCH status wait exp %h got %h", w, s & m);
		end
	endtask : await
	// Whole frame; byte k carries v0 plus k
	task frame(input logic [7:0] op, input logic [11:0] ad, input int nb, input logic [7:0] v0);
		wreg(`HREG_ADDR, {20'h0, ad});
		wreg(`HREG_CMD, {7'h0, op == `OP_RDFS, 7'h0, 9'(nb), op});
		for (int k = 0; k < nb; k++) begin
			await(32'h2, 32'h2);
			wreg(`HREG_DATA, {24'h0, v0 + 8'(k)});
		end
		await(32'h1, 32'h0);
		repeat (6) @(posedge clock);
		#1;
	endtask : frame
	task dev(input logic ew, input logic eb, input logic [7:0] ef);
		chk("wel", {31'h0, ew}, {31'h0, wel});
		chk("busy", {31'h0, eb}, {31'h0, busy});
		chk("fsr", {24'h0, ef}, {24'h0, fsr});
	endtask : dev
	task peek(input logic [11:0] ad, input logic [7:0] e);
		@(posedge clock) mem_addr <= ad;
		repeat (2) @(posedge clock);
		#1 chk("mem", {24'h0, e}, {24'h0, mem_data});
	endtask : peek
	// Program time, then host poll sees ready
	task finish_prog;
		int n;
		n = 0;
		while (busy === 1'b1 && n < 600) begin
			@(posedge clock);
			n++;
		end
		chk("ptime", 1, {31'h0, n > 470 && n <= 500});
		frame(`OP_RDFS, 12'h0, 0, 8'h00);
		chk("ready", 1, {31'h0, s[15]});
	endtask : finish_prog
	task setp(input proto_t p);
		@(posedge clock) proto <= p;
		wreg(`HREG_CFG, {30'h0, p});
	endtask : setp
	initial begin
		repeat (8) @(posedge clock);
		nrst <= 1'b1;
		repeat (2) @(posedge clock);
		#1 dev(0, 0, 8'h80);
		frame(`OP_WREN, 12'h0, 0, 8'h00);
		dev(1, 0, 8'h80);
		frame(`OP_WRDI, 12'h0, 0, 8'h00);
		dev(0, 0, 8'h80);
		frame(`OP_WREN, 12'h0, 1, 8'h00);
		dev(0, 0, 8'h80);
		frame(`OP_WREN, 12'h0, 0, 8'h00);
		frame(`OP_WRDI, 12'h0, 1, 8'h00);
		dev(1, 0, 8'h80);
		frame(`OP_WRDI, 12'h0, 0, 8'h00);
		frame(`OP_PP, 12'h010, 1, 8'hA5);
		dev(0, 0, 8'h80);
		// Program with no data byte is dropped, latch kept
		frame(`OP_WREN, 12'h0, 0, 8'h00);
		frame(`OP_PP, 12'h010, 0, 8'h00);
		dev(1, 0, 8'h80);
		// Every variant in every protocol
		for (int p = 0; p < 3; p++) begin
			for (int i = 0; i < 5; i++) begin
				setp(proto_t'(p));
				a = {4'h2, 4'(p), 4'(i)};
				v = {4'(p), 4'(i)} ^ 8'hC3;
				ok = !((i == 1 || i == 2) && p == 2) && !((i == 3 || i == 4) && p == 1);
				frame(`OP_WREN, 12'h0, 0, 8'h00);
				chk("wel", 1, {31'h0, wel});
				frame(ops[i], a, 1, v);
				dev(1, ok, ok ? 8'h00 : 8'h80);
				if (i == 0) chk("cx", 1, {31'h0, s[2]});
				if (ok) begin
					finish_prog();
					dev(0, 0, 8'h80);
					peek(a, v);
				end else frame(`OP_WRDI, 12'h0, 0, 8'h00);
			end
		end
		// Full page from an unaligned start, then a one-byte patch
		setp(PROTO_QUAD);
		frame(`OP_WREN, 12'h0, 0, 8'h00);
		frame(`OP_QPP, 12'h1FE, 256, 8'h00);
		finish_prog();
		peek(12'h1FE, 8'h00);
		peek(12'h100, 8'h02);
		peek(12'h1FD, 8'hFF);
		frame(`OP_WREN, 12'h0, 0, 8'h00);
		frame(`OP_PP, 12'h180, 1, 8'hEE);
		finish_prog();
		peek(12'h180, 8'hEE);
		peek(12'h181, 8'h83);
		// Locked sector refuses and holds the latch
		setp(PROTO_EXT);
		sector_lock <= 4'h2;
		frame(`OP_WREN, 12'h0, 0, 8'h00);
		frame(`OP_PP, 12'h400, 1, 8'h11);
		dev(1, 0, 8'h92);
		frame(`OP_WRDI, 12'h0, 0, 8'h00);
		dev(1, 0, 8'h92);
		frame(`OP_CLFS, 12'h0, 0, 8'h00);
		dev(0, 0, 8'h80);
		sector_lock <= 4'h0;
		// Forced timeout
		timeout_force <= 1'b1;
		frame(`OP_WREN, 12'h0, 0, 8'h00);
		frame(`OP_PP, 12'h300, 1, 8'h77);
		finish_prog();
		dev(0, 0, 8'h90);
		timeout_force <= 1'b0;
		frame(`OP_CLFS, 12'h0, 0, 8'h00);
		dev(0, 0, 8'h80);
		conclude();
	end
endmodule : test_serial_flash_program_write_enable
